// ---- dswp_pkg.sv ----
// shared constants and types for the converter serial write port
// Notes on behaviour
// - frame select low enables shifting
// - data sampled on shift clock falling edges
// - shift register holds sixteen bits
// - sixteenth edge commits code and mode
// - early frame select rise aborts frame
// - two mode bits then fourteen data
// - mode 00 normal, 01 1k, 10 100k
// - reset clears converter register to zero
// - abort clears shift register and count
`default_nettype none
package dswp_pkg;
    localparam int DSWP_FRAME_BITS = 16;
    localparam int DSWP_CODE_BITS = 14;
    localparam int DSWP_CNT_BITS = 5;
    localparam logic [4:0] DSWP_LAST_CNT = 5'h0F;
    localparam logic [4:0] DSWP_CNT_RESET = 5'h00;
    localparam logic [15:0] DSWP_SHIFT_RESET = 16'h0000;
    localparam logic [13:0] DSWP_CODE_RESET = 14'h0000;
    localparam int DSWP_MODE_HI_POS = 15;
    localparam int DSWP_MODE_LO_POS = 14;
    localparam logic [1:0] DSWP_MODE_NORMAL = 2'h0;
    localparam logic [1:0] DSWP_MODE_PD_1K = 2'h1;
    localparam logic [1:0] DSWP_MODE_PD_100K = 2'h2;
    localparam logic [1:0] DSWP_MODE_RESERVED = 2'h3;
    localparam logic [1:0] DSWP_MODE_RESET = 2'h0;

    typedef struct packed {
        logic [1:0] mode;
        logic [13:0] code;
    } dswp_word_type;

    typedef struct packed {
        logic normal;
        logic pd_1k;
        logic pd_100k;
        logic pd_three_state;
    } dswp_mode_dec_type;

    typedef enum logic [1:0] {
        DSWP_IDLE,
        DSWP_SHIFT,
        DSWP_DONE
    } dswp_state_type;

    // one-hot decode of the two mode bits
    function automatic dswp_mode_dec_type dswp_decode(input logic [1:0] m);
        dswp_mode_dec_type d;
        d.normal = (m == DSWP_MODE_NORMAL);
        d.pd_1k = (m == DSWP_MODE_PD_1K);
        d.pd_100k = (m == DSWP_MODE_PD_100K);
        d.pd_three_state = (m == DSWP_MODE_RESERVED);
        return d;
    endfunction
endpackage
`default_nettype wire

// ---- dswp_sync.sv ----
// two-stage synchroniser with edge outputs on the settled level
`default_nettype none
module dswp_sync
    import dswp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic async_in,
    input wire logic rst_val,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= rst_val;
            sync_reg <= rst_val;
            last_reg <= rst_val;
        end
        else if (clk_en)
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // rst_val must match the pin idle level, else a false edge after reset
    assign level = sync_reg;
    assign rise = clk_en & sync_reg & ~last_reg;
    assign fall = clk_en & ~sync_reg & last_reg;
endmodule
`default_nettype wire

// ---- dswp_port.sv ----
// serial write port: frame capture, commit and abort handling
`default_nettype none
module dswp_port
    import dswp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic frame_select_n,
    input wire logic shift_clock,
    input wire logic serial_data_in,
    output logic [13:0] code_out,
    output logic [1:0] mode_out,
    output logic normal_out,
    output logic pd_1k_out,
    output logic pd_100k_out,
    output logic commit_pulse,
    output logic abort_pulse
);
    logic sel_lvl;
    logic sel_rise;
    logic sclk_fall;
    logic data_meta_reg;
    logic data_reg;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    dswp_state_type state_reg;
    dswp_state_type state_next;
    dswp_word_type word_reg;
    dswp_word_type word_next;
    dswp_mode_dec_type dec_next;
    logic normal_reg;
    logic pd_1k_reg;
    logic pd_100k_reg;
    logic commit_reg;
    logic abort_reg;
    logic take_bit;
    logic last_bit;
    logic do_commit;
    logic do_abort;

    dswp_sync u_sel (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(frame_select_n),
        .rst_val(1'b1),
        .level(sel_lvl),
        .rise(sel_rise),
        .fall()
    );

    dswp_sync u_sclk (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(shift_clock),
        .rst_val(1'b1),
        .level(),
        .rise(),
        .fall(sclk_fall)
    );

    // data delayed two stages to line up with the clock edge detector
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            data_meta_reg <= 1'b0;
            data_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            data_meta_reg <= serial_data_in;
            data_reg <= data_meta_reg;
        end
    end

    assign take_bit = (state_reg == DSWP_SHIFT) && !sel_lvl && sclk_fall;
    assign last_bit = take_bit && (cnt_reg == DSWP_LAST_CNT);
    assign do_commit = last_bit;
    // early rise aborts; edge and rise same cycle cannot occur
    assign do_abort = (state_reg == DSWP_SHIFT) && sel_rise;

    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            DSWP_IDLE:
            begin
                if (!sel_lvl)
                begin
                    state_next = DSWP_SHIFT;
                    shift_next = DSWP_SHIFT_RESET;
                    cnt_next = DSWP_CNT_RESET;
                end
            end
            DSWP_SHIFT:
            begin
                if (do_abort)
                begin
                    state_next = DSWP_IDLE;
                    shift_next = DSWP_SHIFT_RESET;
                    cnt_next = DSWP_CNT_RESET;
                end
                else if (take_bit)
                begin
                    shift_next = {shift_reg[14:0], data_reg};
                    cnt_next = cnt_reg + 5'h01;
                    if (last_bit)
                    begin
                        state_next = DSWP_DONE;
                    end
                end
            end
            DSWP_DONE:
            begin
                // further edges ignored until select goes high
                if (sel_lvl)
                begin
                    state_next = DSWP_IDLE;
                end
            end
            default:
            begin
                state_next = DSWP_IDLE;
            end
        endcase
    end

    // two mode bits lead fourteen code bits
    assign word_next = do_commit ? dswp_word_type'(shift_next) : word_reg;
    assign dec_next = dswp_decode(word_next.mode);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= DSWP_IDLE;
            shift_reg <= DSWP_SHIFT_RESET;
            cnt_reg <= DSWP_CNT_RESET;
            word_reg <= {DSWP_MODE_RESET, DSWP_CODE_RESET};
            normal_reg <= 1'b1;
            pd_1k_reg <= 1'b0;
            pd_100k_reg <= 1'b0;
            commit_reg <= 1'b0;
            abort_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            word_reg <= word_next;
            normal_reg <= dec_next.normal;
            pd_1k_reg <= dec_next.pd_1k;
            pd_100k_reg <= dec_next.pd_100k;
            commit_reg <= do_commit;
            abort_reg <= do_abort;
        end
    end

    assign code_out = word_reg.code;
    assign mode_out = word_reg.mode;
    assign normal_out = normal_reg;
    assign pd_1k_out = pd_1k_reg;
    assign pd_100k_out = pd_100k_reg;
    assign commit_pulse = commit_reg;
    assign abort_pulse = abort_reg;

    chk_commit_loads_word: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && do_commit |=> word_reg == $past(shift_next))
        else $error("commit did not load word");

    // last edge gives one single commit pulse
    sequence dswp_last_edge_seq;
        clk_en && last_bit;
    endsequence
    sequence dswp_commit_seen_seq;
        commit_reg && !abort_reg;
    endsequence
    chk_commit_pulse_once: assert property (
        @(posedge clk) disable iff (sys_rst)
        dswp_last_edge_seq |=> dswp_commit_seen_seq
        ##1 (!commit_reg || !$past(clk_en)))
        else $error("commit pulse not single");

    chk_abort_keeps_word: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && do_abort |=> $stable(word_reg) && !commit_reg)
        else $error("abort changed the word");

    // abort clears count and shift register
    chk_abort_clears_cnt: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && do_abort
        |=> cnt_reg == DSWP_CNT_RESET && shift_reg == DSWP_SHIFT_RESET)
        else $error("abort left bit count");

    chk_idle_no_shift: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && sel_lvl && state_reg != DSWP_SHIFT |=> $stable(cnt_reg))
        else $error("bits taken while deselected");

    chk_edge_counts: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && take_bit && !last_bit
        |=> cnt_reg == $past(cnt_reg) + 5'h01)
        else $error("falling edge not counted");

    chk_count_bound: assert property (
        @(posedge clk) disable iff (sys_rst)
        cnt_reg <= 5'(DSWP_FRAME_BITS))
        else $error("bit count exceeds frame");

    chk_mode_decode: assert property (
        @(posedge clk) disable iff (sys_rst)
        normal_reg == (mode_out == DSWP_MODE_NORMAL)
        && pd_1k_reg == (mode_out == DSWP_MODE_PD_1K)
        && pd_100k_reg == (mode_out == DSWP_MODE_PD_100K))
        else $error("mode decode mismatch");

    chk_word_only_commit: assert property (
        @(posedge clk) disable iff (sys_rst)
        !$stable(word_reg) |-> commit_reg)
        else $error("word changed without commit");
endmodule
`default_nettype wire

// ---- dswp_host_model.sv ----
// host-side serial master model, one write frame per call
`default_nettype none
module dswp_host_model
(
    input wire logic clk,
    output logic frame_select_n,
    output logic shift_clock,
    output logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        frame_select_n = 1'b1;
        shift_clock = 1'b1;
        serial_data_in = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // clock edges with select high, which must be ignored
    task automatic clock_only(input int n);
        for (int i = 0; i < n; i++)
        begin
            serial_data_in <= ~serial_data_in;
            shift_clock <= 1'b0;
            wait_clk(4);
            shift_clock <= 1'b1;
            wait_clk(4);
        end
    endtask
    // n bits of w; fewer than sixteen aborts, more wraps round the word
    task automatic send(input logic [15:0] w, input int n);
        frame_select_n <= 1'b0;
        wait_clk(4);
        for (int i = 0; i < n; i++)
        begin
            // data set while high, held across the fall
            shift_clock <= 1'b1;
            serial_data_in <= w[4'(15 - i)];
            wait_clk(4);
            shift_clock <= 1'b0;
            wait_clk(4);
        end
        shift_clock <= 1'b1;
        wait_clk(4);
        frame_select_n <= 1'b1;
        // released line shows the inverse, never a stale bit
        serial_data_in <= ~serial_data_in;
        wait_clk(8);
    endtask
endmodule
`default_nettype wire

// ---- dswp_port_tb_top.sv ----
// self-checking bench for the serial write port
`default_nettype none
module dswp_port_tb_top
    import dswp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [15:0] word;
        logic [2:0] dec;
    } dswp_row_type;
    dswp_row_type rows [4] = '{'{16'h3FFF, 3'h4}, '{16'h4001, 3'h2},
        '{16'h8000, 3'h1}, '{16'hD555, 3'h0}};
    logic clk;
    logic sys_rst;
    logic clk_en;
    wire logic frame_select_n;
    wire logic shift_clock;
    wire logic serial_data_in;
    logic [13:0] code_out;
    logic [1:0] mode_out;
    logic normal_out;
    logic pd_1k_out;
    logic pd_100k_out;
    logic commit_pulse;
    logic abort_pulse;
    int error_cnt;
    int n_tests;
    int commit_cnt;
    int abort_cnt;
    int cnt_snap;

    dswp_host_model i_dswp_host_model (.clk(clk),
        .frame_select_n(frame_select_n), .shift_clock(shift_clock),
        .serial_data_in(serial_data_in));
    dswp_port i_dswp_port (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .frame_select_n(frame_select_n), .shift_clock(shift_clock),
        .serial_data_in(serial_data_in), .code_out(code_out),
        .mode_out(mode_out), .normal_out(normal_out),
        .pd_1k_out(pd_1k_out), .pd_100k_out(pd_100k_out),
        .commit_pulse(commit_pulse), .abort_pulse(abort_pulse));

    always #25 clk = ~clk;

    // a pulse longer than one cycle counts twice and shows up
    always @(posedge clk)
    begin
        if (commit_pulse === 1'b1)
            commit_cnt++;
        if (abort_pulse === 1'b1)
            abort_cnt++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic frame(input logic [15:0] w, input int n, input bit ok);
        int c0;
        int a0;
        int k;
        c0 = commit_cnt;
        a0 = abort_cnt;
        i_dswp_host_model.send(w, n);
        k = 0;
        while (k < 20 && commit_cnt == c0 && abort_cnt == a0)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 20)
        begin
            error_cnt++;
            $display("mismatch at %0t: no commit or abort seen", $time);
            results();
        end
        check(16'(commit_cnt - c0), 16'(ok));
        check(16'(abort_cnt - a0), 16'(!ok));
    endtask

    task automatic check_out(input logic [15:0] w, input logic [2:0] d);
        check({mode_out, code_out}, w);
        check(16'({normal_out, pd_1k_out, pd_100k_out}), 16'(d));
    endtask

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        error_cnt = 0;
        n_tests = 0;
        commit_cnt = 0;
        abort_cnt = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check_out(16'h0000, 3'h4);
        foreach (rows[i])
        begin
            frame(rows[i].word, 16, 1'b1);
            check_out(rows[i].word, rows[i].dec);
        end
        // fifteen bits then select high leaves the last word standing
        frame(16'h8AAA, 15, 1'b0);
        check_out(16'hD555, 3'h0);
        frame(16'h1234, 16, 1'b1);
        check_out(16'h1234, 3'h4);
        frame(16'h7FFE, 16, 1'b1);
        check_out(16'h7FFE, 3'h2);
        // clock edges with select high leave everything standing
        cnt_snap = commit_cnt + abort_cnt;
        i_dswp_host_model.clock_only(16);
        check(16'(commit_cnt + abort_cnt - cnt_snap), 16'h0000);
        check_out(16'h7FFE, 3'h2);
        // frozen enable: a whole frame must leave no trace
        clk_en <= 1'b0;
        i_dswp_host_model.send(16'h0F0F, 16);
        clk_en <= 1'b1;
        repeat (8) @(posedge clk);
        check(16'(commit_cnt + abort_cnt - cnt_snap), 16'h0000);
        check_out(16'h7FFE, 3'h2);
        // two surplus edges after the sixteenth are ignored
        frame(16'h2C3A, 18, 1'b1);
        check_out(16'h2C3A, 3'h4);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check_out(16'h0000, 3'h4);
        results();
    end
endmodule
`default_nettype wire
